// file: rtl/stim_cfg_pkg.sv
// Purpose: Shared constants for the first stimulus step configuration block
// Assumes: 200 MHz core clock
// Notes:   Offsets are the serial management register addresses
// ============================================================
// Register map and fields
package stim_cfg_pkg;
	localparam logic [7:0] ADDR_DETECT_TIMING = 8'h31;
	localparam logic [7:0] ADDR_RESPONSE      = 8'h32;
	localparam logic [7:0] RESET_DETECT_TIMING = 8'h00;
	localparam logic [7:0] RESET_RESPONSE      = 8'h00;
	localparam int TIMER_BEHAVIOUR_POS = 6;
	localparam int DELAY_SELECT_LSB    = 3;
	localparam int TRIGGER_SELECT_LSB  = 0;
	localparam int REPLY_MAG_LSB       = 4;
	localparam int REPLY_KIND_LSB      = 0;

	// ============================================================
	// Trigger select codes
	localparam logic [2:0] TRIG_VBUS_BEFORE_SWITCH = 3'h0;
	localparam logic [2:0] TRIG_DP_ABOVE           = 3'h1;
	localparam logic [2:0] TRIG_DP_IN_BAND         = 3'h2;
	localparam logic [2:0] TRIG_DM_ABOVE           = 3'h3;
	localparam logic [2:0] TRIG_RESERVED_A         = 3'h4;
	localparam logic [2:0] TRIG_RESERVED_B         = 3'h5;
	localparam logic [2:0] TRIG_DP_BELOW           = 3'h6;
	localparam logic [2:0] TRIG_VBUS_AFTER_SWITCH  = 3'h7;

	// ============================================================
	// Reply kind and magnitude codes
	localparam logic [3:0] KIND_REMOVE     = 4'h0;
	localparam logic [3:0] KIND_RESERVED_A = 4'h5;
	localparam logic [3:0] KIND_RESERVED_B = 4'h8;
	localparam logic [3:0] KIND_RESERVED_C = 4'hb;
	localparam logic [3:0] MAG_RESERVED    = 4'hf;

	// ============================================================
	// Timing
	localparam int CLOCK_HZ        = 200_000_000;
	localparam int MS_PER_SECOND   = 1000;
	localparam int CYCLES_PER_MS   = CLOCK_HZ / MS_PER_SECOND;
	localparam int DELAY_CODE0_MS  = 0;
	localparam int DELAY_CODE1_MS  = 1;
	localparam int DELAY_CODE2_MS  = 5;
	localparam int DELAY_CODE3_MS  = 10;
	localparam int DELAY_CODE4_MS  = 20;
	localparam int DELAY_CODE5_MS  = 40;
	localparam int DELAY_CODE6_MS  = 80;
	localparam int DELAY_CODE7_MS  = 100;

	// Delay select code to milliseconds
	function automatic logic [6:0] delay_ms(input logic [2:0] code);
		logic [6:0] ms;
		ms = 7'(DELAY_CODE0_MS);
		unique case (code)
			3'h0: ms = 7'(DELAY_CODE0_MS);
			3'h1: ms = 7'(DELAY_CODE1_MS);
			3'h2: ms = 7'(DELAY_CODE2_MS);
			3'h3: ms = 7'(DELAY_CODE3_MS);
			3'h4: ms = 7'(DELAY_CODE4_MS);
			3'h5: ms = 7'(DELAY_CODE5_MS);
			3'h6: ms = 7'(DELAY_CODE6_MS);
			3'h7: ms = 7'(DELAY_CODE7_MS);
		endcase
		return ms;
	endfunction : delay_ms
endpackage : stim_cfg_pkg

// file: rtl/stim_step_one.sv
// Purpose: First stimulus step configuration registers and its sequencer
// Assumes: Loader writes come from the emulation engine on ref_clk_i
// Notes:   Comparator and power inputs are pins and are synchronised
//
// Functional notes
// - Read-only register 0x31, 8 bits, top bit always reads zero.
// - Delay codes 000, 001, 010 select 0, 1 and 5 ms.
// - Delay codes 011 to 111 select 10, 20, 40, 80, 100 ms.
// - Timer bit: apply at once and hold, or apply after qualified detection.
// - Trigger 000: bus voltage before switch closes; step waits for it.
// - Trigger 001: positive data line above threshold is the stimulus.
// - Trigger 100, 101 reserved; 010, 011, 110 compare data lines; 111 (bus after switch) always hits.
// - Reply magnitude in upper nibble of 0x32, meaning depends on reply kind.
// - Reserved field values are refused; the field keeps its old value.
// - Registers are filled from internal memory for the active profile.
// - Register 0x31 is lost in sleep and reloaded on resume.
// - Reply kind 0000 removes any reply from both data lines.
`timescale 1ns/10ps
`default_nettype none

module stim_step_one
	import stim_cfg_pkg::*;
#(
	parameter int MS_CYCLES = CYCLES_PER_MS
) (
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       load_valid_i,
	input  wire logic [7:0] load_addr_i,
	input  wire logic [7:0] load_data_i,
	input  wire logic       sleep_i,
	input  wire logic [7:0] rd_addr_i,
	input  wire logic       step_start_i,
	input  wire logic       vbus_present_i,
	input  wire logic       switch_closed_i,
	input  wire logic       dp_above_i,
	input  wire logic       dp_in_band_i,
	input  wire logic       dm_above_i,
	output logic      [7:0] rd_data_o,
	output logic            reply_active_o,
	output logic      [3:0] reply_kind_o,
	output logic      [3:0] reply_magnitude_o,
	output logic            step_done_o,
	output logic            step_busy_o
);
	// ============================================================
	// State
	typedef enum logic [2:0] {IDLE, WAIT_STIM, QUALIFY, HOLD, DONE} seq_t;

	typedef struct packed {
		logic [6:0]  timing;      // Bit 7 of 0x31 is not stored
		logic [7:0]  response;
		seq_t        seq;
		logic [17:0] prescale;
		logic [6:0]  ms_count;
		logic [4:0]  sync1;
		logic [4:0]  sync2;
		logic        reply_active;
		logic [3:0]  reply_kind;
		logic [3:0]  reply_mag;
		logic        done;
		logic        busy;        // Registered so the pin comes straight from a flop
		logic [7:0]  rd_data;
	} state_t;

	state_t st;
	state_t next_st;

	logic       vbus_s;
	logic       switch_s;
	logic       dp_above_s;
	logic       dp_band_s;
	logic       dm_above_s;
	logic       stim_hit;
	logic       delay_over;
	logic       hold_mode;
	logic [2:0] trig_sel;
	logic [2:0] new_trig;
	logic [3:0] new_kind;
	logic [3:0] new_mag;

	// Only the second synchroniser stage feeds logic
	assign {vbus_s, switch_s, dp_above_s, dp_band_s, dm_above_s} = st.sync2;
	assign trig_sel  = st.timing[TRIGGER_SELECT_LSB +: 3];
	assign hold_mode = st.timing[TIMER_BEHAVIOUR_POS];
	assign new_trig  = load_data_i[TRIGGER_SELECT_LSB +: 3];
	assign new_kind  = load_data_i[REPLY_KIND_LSB +: 4];
	assign new_mag   = load_data_i[REPLY_MAG_LSB +: 4];

	// ============================================================
	// Stimulus condition decode
	always_comb begin
		stim_hit = 1'b0;
		unique case (trig_sel)
			TRIG_VBUS_BEFORE_SWITCH: stim_hit = vbus_s & ~switch_s;
			TRIG_DP_ABOVE:           stim_hit = dp_above_s;
			TRIG_DP_IN_BAND:         stim_hit = dp_band_s;
			TRIG_DM_ABOVE:           stim_hit = dm_above_s;
			TRIG_DP_BELOW:           stim_hit = ~dp_above_s;
			// Bus after switch does not hold the step back
			TRIG_VBUS_AFTER_SWITCH:  stim_hit = 1'b1;
			// Reserved codes can never be stored, so they never trigger
			TRIG_RESERVED_A,
			TRIG_RESERVED_B:         stim_hit = 1'b0;
		endcase
	end

	// Delay reached when whole milliseconds reach or pass the selected figure
	assign delay_over = (st.ms_count >= delay_ms(st.timing[DELAY_SELECT_LSB +: 3]));

	// ============================================================
	// Next state
	always_comb begin
		next_st       = st;
		next_st.sync1 = {vbus_present_i, switch_closed_i, dp_above_i, dp_in_band_i, dm_above_i};
		next_st.sync2 = st.sync1;
		next_st.done  = 1'b0;

		// Loader writes, reserved values refused field by field
		if (load_valid_i && load_addr_i == ADDR_DETECT_TIMING) begin
			next_st.timing[TIMER_BEHAVIOUR_POS] = load_data_i[TIMER_BEHAVIOUR_POS];
			next_st.timing[DELAY_SELECT_LSB +: 3] = load_data_i[DELAY_SELECT_LSB +: 3];
			if (new_trig != TRIG_RESERVED_A && new_trig != TRIG_RESERVED_B) begin
				next_st.timing[TRIGGER_SELECT_LSB +: 3] = new_trig;
			end
		end
		if (load_valid_i && load_addr_i == ADDR_RESPONSE) begin
			if (new_kind != KIND_RESERVED_A && new_kind != KIND_RESERVED_B &&
			    new_kind != KIND_RESERVED_C) begin
				next_st.response[REPLY_KIND_LSB +: 4] = new_kind;
			end
			if (new_mag != MAG_RESERVED) begin
				next_st.response[REPLY_MAG_LSB +: 4] = new_mag;
			end
		end
		// Sleep drops the detect settings; the engine reloads on resume
		if (sleep_i) begin
			next_st.timing = RESET_DETECT_TIMING[6:0];
		end

		// Millisecond timebase, runs only while a delay is counted
		if (st.seq == QUALIFY || st.seq == HOLD) begin
			if (st.prescale == 18'(MS_CYCLES - 1)) begin
				next_st.prescale = '0;
				next_st.ms_count = st.ms_count + 7'h01;
			end else begin
				next_st.prescale = st.prescale + 18'h00001;
			end
		end else begin
			next_st.prescale = '0;
			next_st.ms_count = '0;
		end

		// Step sequencer
		unique case (st.seq)
			IDLE: begin
				if (step_start_i && !sleep_i) begin
					next_st.seq = WAIT_STIM;
				end
			end
			WAIT_STIM: begin
				if (stim_hit) begin
					if (hold_mode) begin
						// Reply goes out at once and is held for the delay
						next_st.reply_kind   = st.response[REPLY_KIND_LSB +: 4];
						next_st.reply_mag    = st.response[REPLY_MAG_LSB +: 4];
						next_st.reply_active = (st.response[REPLY_KIND_LSB +: 4] != KIND_REMOVE);
						next_st.seq          = HOLD;
					end else begin
						next_st.seq = QUALIFY;
					end
				end
			end
			QUALIFY: begin
				if (!stim_hit) begin
					// Stimulus dropped before the delay ran out: start over
					next_st.seq = WAIT_STIM;
				end else if (delay_over) begin
					next_st.reply_kind   = st.response[REPLY_KIND_LSB +: 4];
					next_st.reply_mag    = st.response[REPLY_MAG_LSB +: 4];
					next_st.reply_active = (st.response[REPLY_KIND_LSB +: 4] != KIND_REMOVE);
					next_st.seq          = DONE;
				end
			end
			HOLD: begin
				if (delay_over) begin
					if (!stim_hit) begin
						next_st.reply_active = 1'b0;
					end
					next_st.seq = DONE;
				end
			end
			DONE: begin
				next_st.done = 1'b1;
				next_st.seq  = IDLE;
			end
			default: next_st.seq = IDLE;
		endcase
		if (sleep_i) begin
			next_st.seq = IDLE;
		end
		// Busy follows the state that is about to be entered, so it lines up with seq
		next_st.busy = (next_st.seq != IDLE);

		// Registered read port, unmapped addresses read zero
		if (rd_addr_i == ADDR_DETECT_TIMING) begin
			next_st.rd_data = {1'b0, st.timing};
		end else if (rd_addr_i == ADDR_RESPONSE) begin
			next_st.rd_data = st.response;
		end else begin
			next_st.rd_data = 8'h00;
		end
	end

	// ============================================================
	// State register
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= '{timing: RESET_DETECT_TIMING[6:0], response: RESET_RESPONSE, seq: IDLE,
			        default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign rd_data_o         = st.rd_data;
	assign reply_active_o    = st.reply_active;
	assign reply_kind_o      = st.reply_kind;
	assign reply_magnitude_o = st.reply_mag;
	assign step_done_o       = st.done;
	assign step_busy_o       = st.busy;
endmodule : stim_step_one

`default_nettype wire

// file: verification/stim_step_one_chk.sv
// Purpose: Port checks for the first stimulus step block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Watches design outputs against their causes
`timescale 1ns/10ps
`default_nettype none
module stim_step_one_chk (
	input wire logic       ref_clk_i,
	input wire logic       nrst_i,
	input wire logic       sleep_i,
	input wire logic       step_start_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic [7:0] rd_data_o,
	input wire logic       reply_active_o,
	input wire logic [3:0] reply_kind_o,
	input wire logic [3:0] reply_magnitude_o,
	input wire logic       step_done_o,
	input wire logic       step_busy_o
);
	// ==========
	// Properties
	// One domain, so clock and reset are given once
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	a_rd_unmapped: assert property (
		!(rd_addr_i inside {8'h31, 8'h32}) |=> rd_data_o == 8'h00) else $error("unmapped read");
	a_top_bit_zero: assert property (
		rd_addr_i == 8'h31 |=> !rd_data_o[7]) else $error("top bit set");
	a_done_pulse: assert property (
		step_done_o |=> !step_done_o) else $error("done too long");
	a_done_idle: assert property (
		step_done_o && !step_start_i |=> !step_busy_o) else $error("busy after done");
	a_busy_start: assert property (
		!step_busy_o && step_start_i && !sleep_i |=> step_busy_o) else $error("no start");
	// Two sleep samples in a row must have emptied the timing register
	a_sleep_clear: assert property (
		$past(sleep_i, 2) && $past(sleep_i) && $past(rd_addr_i) == 8'h31 |-> rd_data_o == 8'h00)
		else $error("timing kept in sleep");
	a_kind_cause: assert property (
		$rose(reply_active_o) |-> reply_kind_o != 4'h0) else $error("remove kind active");
	a_no_reserved: assert property (
		!(reply_kind_o inside {4'h5, 4'h8, 4'hb}) && reply_magnitude_o != 4'hf)
		else $error("reserved reply");
	a_reply_in_step: assert property (
		$changed({reply_kind_o, reply_magnitude_o}) |-> $past(step_busy_o))
		else $error("reply outside step");
endmodule : stim_step_one_chk
`default_nettype wire

// file: verification/portable_dev_model.sv
// Purpose: Attached portable device driving the stimulus pins
// Assumes: Comparator results modelled as plain levels
// Notes:   Pins follow the requested trigger, changing as want_i and on_i change at the edge
`timescale 1ns/10ps
`default_nettype none
module portable_dev_model (
	input  wire logic [2:0] want_i,
	input  wire logic       on_i,
	output logic            vbus_o,
	output logic            sw_o,
	output logic            dp_above_o,
	output logic            dp_band_o,
	output logic            dm_above_o
);
	// ==========
	// Stimulus pins
	// Below-threshold trigger needs the upper comparator low when present
	assign vbus_o     = on_i;
	assign sw_o       = on_i && (want_i == 3'h7);
	assign dp_above_o = on_i ^ (want_i == 3'h6);
	assign dp_band_o  = on_i;
	assign dm_above_o = on_i;
endmodule : portable_dev_model
`default_nettype wire

// file: verification/stim_step_one_test.sv
// Purpose: Self-checking bench for the first stimulus step block
// Assumes: MS_CYCLES shortened to 4 cycles per ms
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/10ps
`default_nettype none
module stim_step_one_test;
	localparam int MSC = 4;
	logic       ref_clk_i, nrst_i, load_valid_i, sleep_i, step_start_i, on;
	logic [7:0] load_addr_i, load_data_i, rd_addr_i, rd_data_o;
	logic       vbus_present_i, switch_closed_i, dp_above_i, dp_in_band_i, dm_above_i;
	logic       reply_active_o, step_done_o, step_busy_o;
	logic [3:0] reply_kind_o, reply_magnitude_o;
	logic [2:0] want;
	logic [3:0] rk[3] = '{4'h5, 4'h8, 4'hb};
	logic [2:0] tc[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	int         bad_count = 0;
	int         checks = 0;
	int         ms[8] = '{0, 1, 5, 10, 20, 40, 80, 100};
	stim_step_one #(.MS_CYCLES(MSC)) dut (.ref_clk_i, .nrst_i, .load_valid_i, .load_addr_i,
		.load_data_i, .sleep_i, .rd_addr_i, .step_start_i, .vbus_present_i, .switch_closed_i,
		.dp_above_i, .dp_in_band_i, .dm_above_i, .rd_data_o, .reply_active_o, .reply_kind_o,
		.reply_magnitude_o, .step_done_o, .step_busy_o);
	portable_dev_model pdev (.want_i(want), .on_i(on), .vbus_o(vbus_present_i),
		.sw_o(switch_closed_i), .dp_above_o(dp_above_i), .dp_band_o(dp_in_band_i),
		.dm_above_o(dm_above_i));
	// ==========
	// Tasks
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic ld_w(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		load_valid_i <= 1'b1;
		load_addr_i  <= a;
		load_data_i  <= d;
		@(posedge ref_clk_i);
		load_valid_i <= 1'b0;
	endtask : ld_w
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i);
		rd_addr_i <= a;
		@(posedge ref_clk_i);
		#1 chk({1'b0, rd_data_o}, {1'b0, exp}, "read");
	endtask : rd
	// Stimulus is dropped at the start edge when keep is low
	task automatic run(input logic [7:0] c31, input logic [7:0] c32, input logic keep,
			input int d, input logic [8:0] ex);
		int n;
		@(posedge ref_clk_i);
		want <= c31[2:0];
		on   <= 1'b1;
		ld_w(8'h31, c31);
		ld_w(8'h32, c32);
		@(posedge ref_clk_i);
		step_start_i <= 1'b1;
		@(posedge ref_clk_i);
		step_start_i <= 1'b0;
		on           <= keep;
		for (n = 0; n < 1000 && step_done_o !== 1'b1; n++) begin
			@(posedge ref_clk_i);
			#1;
			if (n == 0) begin
				chk({8'h00, step_busy_o}, 9'h001, "busy after start");
			end
		end
		// A hung step counts once; the sequence runs on to the closing report
		if (n == 1000) begin
			bad_count++;
			$display("[ERR] %0t step never finished", $time);
		end else begin
			chk(9'(n >= d * MSC && n <= d * MSC + 16), 9'h001, "step time");
			chk({reply_active_o, reply_kind_o, reply_magnitude_o}, ex, "reply");
			chk({8'h00, step_busy_o}, 9'h000, "busy after done");
		end
	endtask : run
	// ==========
	// Clock and sequence
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	// Reserved writes are mixed with legal fields to show only the field is refused
	initial begin
		{nrst_i, load_valid_i, sleep_i, step_start_i, on, want} = '0;
		{load_addr_i, load_data_i, rd_addr_i} = '0;
		repeat (8) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		rd(8'h31, 8'h00);
		rd(8'h32, 8'h00);
		rd(8'h30, 8'h00);
		ld_w(8'h31, 8'hcb);
		rd(8'h31, 8'h4b);
		ld_w(8'h31, 8'h2c);
		rd(8'h31, 8'h2b);
		ld_w(8'h31, 8'h25);
		rd(8'h31, 8'h23);
		ld_w(8'h32, 8'h21);
		ld_w(8'h32, 8'hf3);
		rd(8'h32, 8'h23);
		foreach (rk[i]) begin
			ld_w(8'h32, {4'h4, rk[i]});
			rd(8'h32, 8'h43);
		end
		$display("register test done");
		@(posedge ref_clk_i);
		sleep_i <= 1'b1;
		rd(8'h31, 8'h00);
		rd(8'h32, 8'h43);
		@(posedge ref_clk_i);
		sleep_i <= 1'b0;
		$display("sleep test done");
		foreach (tc[i])
			run({2'b00, tc[i], tc[i]}, 8'h21, 1'b1, ms[tc[i]], 9'h112);
		run(8'h51, 8'h34, 1'b0, 5, 9'h043);
		run(8'h47, 8'h50, 1'b1, 0, 9'h005);
		$display("sequencer test done");
		wrap_up();
	end
endmodule : stim_step_one_test
bind stim_step_one stim_step_one_chk chk (.ref_clk_i, .nrst_i, .sleep_i, .step_start_i,
	.rd_addr_i, .rd_data_o, .reply_active_o, .reply_kind_o, .reply_magnitude_o,
	.step_done_o, .step_busy_o);
`default_nettype wire
